/* File: sls_pkg.sv */
// Constants, types and parameter map for the servo limit selection block
package sls_pkg;

  // Parameter offsets on the fieldbus map
  localparam logic [15:0] OFS_DI_VLIM = 16'h063c;
  localparam logic [15:0] OFS_CH1_USAGE = 16'h091c;
  localparam logic [15:0] OFS_CH1_VFS = 16'h0920;
  localparam logic [15:0] OFS_CH2_USAGE = 16'h0926;
  localparam logic [15:0] OFS_CH2_VFS = 16'h092a;
  localparam logic [15:0] OFS_QS_CURRENT = 16'h111a;

  // Values after reset
  localparam logic [31:0] RST_DI_VLIM = 32'h0000000a;
  localparam logic [15:0] RST_CH1_USAGE = 16'h0001;
  localparam logic [15:0] RST_CH2_USAGE = 16'h0000;
  localparam logic [31:0] RST_VFS = 32'h00000bb8;
  localparam logic [15:0] RST_QS_CURRENT = 16'hffff;

  // Value ranges
  localparam logic [15:0] QS_CURRENT_MIN = 16'h0000;
  localparam logic [15:0] QS_CURRENT_MAX = 16'hffff;
  localparam logic [15:0] CH1_USAGE_MAX = 16'h0004;
  localparam logic [15:0] CH2_USAGE_MAX = 16'h0005;
  localparam logic [31:0] VFS_MIN = 32'h00000001;
  localparam logic [31:0] VLIM_MAX = 32'h7fffffff;

  // Velocity floor in rpm
  localparam logic [31:0] VEL_FLOOR_RPM = 32'h00000064;

  // Analog code magnitude that stands for 10 V; power of two keeps scaling a shift
  localparam int ADC_FS_SHIFT = 15;

  // Usage codes
  localparam logic [15:0] USE_NONE = 16'h0000;
  localparam logic [15:0] USE_VEL_LIMIT = 16'h0003;

  // Operating mode as seen by this block
  typedef enum logic [1:0] {
    SLS_MODE_OTHER,
    SLS_MODE_PTORQUE,
    SLS_MODE_PVEL
  } sls_mode_t;

  // Parameter access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } sls_par_req_t;

  // Parameter access answer
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } sls_par_rsp_t;

endpackage : sls_pkg

/* File: sls_sync.sv */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sls_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;

  // First stage feeds only the second
  always_comb
  begin
    meta_d = pin;
    level_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      level_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule : sls_sync

/* File: sls_vscale.sv */
// One analog channel: optional inversion and scaling to a velocity limit
`timescale 1ns/1ps
module sls_vscale (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic signed [15:0] ain,
  input wire logic invert,
  input wire logic [31:0] fullscale,
  output logic signed [15:0] eval,
  output logic [31:0] vlim
);

  logic signed [15:0] eval_q;
  logic signed [15:0] eval_d;
  logic [31:0] vlim_q;
  logic [31:0] vlim_d;
  logic [15:0] mag;
  logic [47:0] prod;

  // Inversion saturates the one code with no positive twin
  always_comb
  begin
    if (!invert)
      eval_d = ain;
    else if (ain == 16'sh8000)
      eval_d = 16'sh7fff;
    else
      eval_d = -ain;
    mag = ain[15] ? 16'(-ain) : 16'(ain);
    prod = 48'(mag) * 48'(fullscale);
    vlim_d = prod[sls_pkg::ADC_FS_SHIFT +: 32];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eval_q <= '0;
      vlim_q <= '0;
    end
    else
    begin
      eval_q <= eval_d;
      vlim_q <= vlim_d;
    end
  end

  assign eval = eval_q;
  assign vlim = vlim_q;

endmodule : sls_vscale

/* File: sls_limit_select.sv */
// Current and velocity limit selection with its parameter map
`timescale 1ns/1ps
module sls_limit_select (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sls_pkg::sls_par_req_t par_req,
  output sls_pkg::sls_par_rsp_t par_rsp,
  input wire logic stage_enabled,
  input wire logic quick_stop_active,
  input wire sls_pkg::sls_mode_t op_mode,
  input wire logic [15:0] motor_max_current,
  input wire logic [15:0] power_stage_max_current,
  input wire logic [15:0] thermal_overload_monitor,
  input wire logic [31:0] global_max_velocity,
  input wire logic signed [15:0] analog_input_one,
  input wire logic signed [15:0] analog_input_two,
  input wire logic invert_ch1_pin,
  input wire logic invert_ch2_pin,
  input wire logic vel_limit_pin,
  output logic [15:0] current_limit,
  output logic [31:0] velocity_limit,
  output logic velocity_limit_active,
  output logic signed [15:0] analog_ch1_eval,
  output logic signed [15:0] analog_ch2_eval,
  output logic [15:0] analog_ch1_usage_act,
  output logic [15:0] analog_ch2_usage_act
);

  // Stored parameters
  logic [31:0] di_vlim_q, di_vlim_d;
  logic [15:0] ch1_use_q, ch1_use_d, ch2_use_q, ch2_use_d;
  logic [31:0] ch1_vfs_q, ch1_vfs_d, ch2_vfs_q, ch2_vfs_d;
  logic [15:0] qs_cur_q, qs_cur_d;
  // Copies that take effect at stage enable
  logic [15:0] ch1_use_act_q, ch1_use_act_d, ch2_use_act_q, ch2_use_act_d;
  logic [31:0] ch1_vfs_act_q, ch1_vfs_act_d, ch2_vfs_act_q, ch2_vfs_act_d;
  logic stage_q;
  sls_pkg::sls_par_rsp_t rsp_q, rsp_d;
  logic [15:0] cur_lim_q, cur_lim_d;
  logic [31:0] vlim_q, vlim_d;
  logic vact_q, vact_d;
  logic [2:0] pins_sync;
  logic inv1, inv2, vlim_di;
  logic signed [15:0] eval1, eval2;
  logic [31:0] raw1, raw2;
  logic inv_allowed, stage_rise, wr_locked;
  logic [31:0] a1, a2, dl;

  sls_sync #(.W(3)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin({vel_limit_pin, invert_ch2_pin, invert_ch1_pin}),
    .level(pins_sync)
  );

  // Inversion only in the two profile modes
  assign inv_allowed = (op_mode == sls_pkg::SLS_MODE_PTORQUE) || (op_mode == sls_pkg::SLS_MODE_PVEL);
  assign inv1 = pins_sync[0] && inv_allowed;
  assign inv2 = pins_sync[1] && inv_allowed;
  assign vlim_di = pins_sync[2];

  sls_vscale u_ch1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ain(analog_input_one),
    .invert(inv1),
    .fullscale(ch1_vfs_act_q),
    .eval(eval1),
    .vlim(raw1)
  );

  sls_vscale u_ch2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ain(analog_input_two),
    .invert(inv2),
    .fullscale(ch2_vfs_act_q),
    .eval(eval2),
    .vlim(raw2)
  );

  // Parameter writes and reads; usage and full scale locked while stage runs
  assign wr_locked = stage_enabled;
  always_comb
  begin
    di_vlim_d = di_vlim_q;
    ch1_use_d = ch1_use_q;
    ch2_use_d = ch2_use_q;
    ch1_vfs_d = ch1_vfs_q;
    ch2_vfs_d = ch2_vfs_q;
    qs_cur_d = qs_cur_q;
    rsp_d = '0;
    if (par_req.wr)
    begin
      rsp_d.ack = 1'b1;
      unique case (par_req.addr)
        sls_pkg::OFS_DI_VLIM:
          if (par_req.wdata <= sls_pkg::VLIM_MAX) di_vlim_d = par_req.wdata;
          else rsp_d.err = 1'b1;
        sls_pkg::OFS_CH1_USAGE:
          if (!wr_locked && par_req.wdata <= 32'(sls_pkg::CH1_USAGE_MAX)) ch1_use_d = par_req.wdata[15:0];
          else rsp_d.err = 1'b1;
        sls_pkg::OFS_CH2_USAGE:
          if (!wr_locked && par_req.wdata <= 32'(sls_pkg::CH2_USAGE_MAX)) ch2_use_d = par_req.wdata[15:0];
          else rsp_d.err = 1'b1;
        sls_pkg::OFS_CH1_VFS:
          if (!wr_locked && par_req.wdata >= sls_pkg::VFS_MIN && par_req.wdata <= sls_pkg::VLIM_MAX)
            ch1_vfs_d = par_req.wdata;
          else rsp_d.err = 1'b1;
        sls_pkg::OFS_CH2_VFS:
          if (!wr_locked && par_req.wdata >= sls_pkg::VFS_MIN && par_req.wdata <= sls_pkg::VLIM_MAX)
            ch2_vfs_d = par_req.wdata;
          else rsp_d.err = 1'b1;
        sls_pkg::OFS_QS_CURRENT:
          // Only own range, never clamped to motor or stage ratings
          if (par_req.wdata[31:16] == 16'h0000 && par_req.wdata[15:0] >= sls_pkg::QS_CURRENT_MIN
              && par_req.wdata[15:0] <= sls_pkg::QS_CURRENT_MAX)
            qs_cur_d = par_req.wdata[15:0];
          else rsp_d.err = 1'b1;
        default: rsp_d.err = 1'b1;
      endcase
    end
    else if (par_req.rd)
    begin
      rsp_d.ack = 1'b1;
      unique case (par_req.addr)
        sls_pkg::OFS_DI_VLIM: rsp_d.rdata = di_vlim_q;
        sls_pkg::OFS_CH1_USAGE: rsp_d.rdata = {16'h0000, ch1_use_q};
        sls_pkg::OFS_CH2_USAGE: rsp_d.rdata = {16'h0000, ch2_use_q};
        sls_pkg::OFS_CH1_VFS: rsp_d.rdata = ch1_vfs_q;
        sls_pkg::OFS_CH2_VFS: rsp_d.rdata = ch2_vfs_q;
        sls_pkg::OFS_QS_CURRENT: rsp_d.rdata = {16'h0000, qs_cur_q};
        default: rsp_d.err = 1'b1;
      endcase
    end
  end

  // Staged values move to the working copies on the enable edge only
  assign stage_rise = stage_enabled && !stage_q;
  always_comb
  begin
    ch1_use_act_d = ch1_use_act_q;
    ch2_use_act_d = ch2_use_act_q;
    ch1_vfs_act_d = ch1_vfs_act_q;
    ch2_vfs_act_d = ch2_vfs_act_q;
    if (stage_rise)
    begin
      ch1_use_act_d = ch1_use_q;
      ch2_use_act_d = ch2_use_q;
      ch1_vfs_act_d = ch1_vfs_q;
      ch2_vfs_act_d = ch2_vfs_q;
    end
  end

  // Current limit: lowest of ratings, thermal reduction, stop current during Quick Stop
  always_comb
  begin
    cur_lim_d = motor_max_current;
    if (power_stage_max_current < cur_lim_d) cur_lim_d = power_stage_max_current;
    if (quick_stop_active && qs_cur_q < cur_lim_d) cur_lim_d = qs_cur_q;
    if (thermal_overload_monitor < cur_lim_d) cur_lim_d = thermal_overload_monitor;
  end

  // Analog sources clamped, digital one floored in profile torque only, then the lowest active one wins
  always_comb
  begin
    a1 = raw1;
    if (a1 > global_max_velocity) a1 = global_max_velocity;
    if (a1 < sls_pkg::VEL_FLOOR_RPM) a1 = sls_pkg::VEL_FLOOR_RPM;
    a2 = raw2;
    if (a2 > global_max_velocity) a2 = global_max_velocity;
    if (a2 < sls_pkg::VEL_FLOOR_RPM) a2 = sls_pkg::VEL_FLOOR_RPM;
    dl = di_vlim_q;
    if (op_mode == sls_pkg::SLS_MODE_PTORQUE && dl < sls_pkg::VEL_FLOOR_RPM) dl = sls_pkg::VEL_FLOOR_RPM;
    vact_d = 1'b0;
    vlim_d = sls_pkg::VLIM_MAX;
    if (ch1_use_act_q == sls_pkg::USE_VEL_LIMIT)
    begin
      vact_d = 1'b1;
      vlim_d = a1;
    end
    if (ch2_use_act_q == sls_pkg::USE_VEL_LIMIT)
    begin
      vact_d = 1'b1;
      if (a2 < vlim_d) vlim_d = a2;
    end
    if (vlim_di)
    begin
      vact_d = 1'b1;
      if (dl < vlim_d) vlim_d = dl;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      di_vlim_q <= sls_pkg::RST_DI_VLIM;
      ch1_use_q <= sls_pkg::RST_CH1_USAGE;
      ch2_use_q <= sls_pkg::RST_CH2_USAGE;
      ch1_vfs_q <= sls_pkg::RST_VFS;
      ch2_vfs_q <= sls_pkg::RST_VFS;
      qs_cur_q <= sls_pkg::RST_QS_CURRENT;
      ch1_use_act_q <= sls_pkg::RST_CH1_USAGE;
      ch2_use_act_q <= sls_pkg::RST_CH2_USAGE;
      ch1_vfs_act_q <= sls_pkg::RST_VFS;
      ch2_vfs_act_q <= sls_pkg::RST_VFS;
      stage_q <= 1'b0;
      rsp_q <= '0;
      cur_lim_q <= '0;
      vlim_q <= sls_pkg::VLIM_MAX;
      vact_q <= 1'b0;
    end
    else
    begin
      di_vlim_q <= di_vlim_d;
      ch1_use_q <= ch1_use_d;
      ch2_use_q <= ch2_use_d;
      ch1_vfs_q <= ch1_vfs_d;
      ch2_vfs_q <= ch2_vfs_d;
      qs_cur_q <= qs_cur_d;
      ch1_use_act_q <= ch1_use_act_d;
      ch2_use_act_q <= ch2_use_act_d;
      ch1_vfs_act_q <= ch1_vfs_act_d;
      ch2_vfs_act_q <= ch2_vfs_act_d;
      stage_q <= stage_enabled;
      rsp_q <= rsp_d;
      cur_lim_q <= cur_lim_d;
      vlim_q <= vlim_d;
      vact_q <= vact_d;
    end
  end

  assign par_rsp = rsp_q;
  assign current_limit = cur_lim_q;
  assign velocity_limit = vlim_q;
  assign velocity_limit_active = vact_q;
  assign analog_ch1_eval = eval1;
  assign analog_ch2_eval = eval2;
  assign analog_ch1_usage_act = ch1_use_act_q;
  assign analog_ch2_usage_act = ch2_use_act_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_locked_write;
    par_req.wr && stage_enabled && par_req.addr == sls_pkg::OFS_CH1_USAGE;
  endsequence

  AST_QS_BELOW_STOP_CURRENT: assert property (quick_stop_active |=> current_limit <= $past(qs_cur_q))
    else $error("quick stop limit above stop current");
  AST_LIMIT_BELOW_THERMAL: assert property (1'b1 |=> current_limit <= $past(thermal_overload_monitor))
    else $error("current limit above thermal limit");
  AST_LIMIT_BELOW_STAGE: assert property (1'b1 |=> current_limit <= $past(power_stage_max_current)
      && current_limit <= $past(motor_max_current))
    else $error("current limit above ratings");
  AST_QS_WRITE_KEEPS: assert property (par_req.wr && par_req.addr == sls_pkg::OFS_QS_CURRENT
      && par_req.wdata[31:16] == 16'h0000 |=> qs_cur_q == $past(par_req.wdata[15:0]) && !par_rsp.err)
    else $error("stop current not stored as written");
  AST_LOCKED_WRITE_REFUSED: assert property (s_locked_write |=> par_rsp.err && $stable(ch1_use_q))
    else $error("usage write taken while stage enabled");
  AST_ACT_HOLD: assert property (stage_enabled && stage_q |=> $stable(ch1_use_act_q) && $stable(ch2_vfs_act_q))
    else $error("working copy changed while stage enabled");
  AST_ACT_LOAD: assert property ($rose(stage_enabled) |=> ch1_use_act_q == $past(ch1_use_q)
      && ch2_vfs_act_q == $past(ch2_vfs_q))
    else $error("working copy not loaded on enable");
  AST_CH1_RANGE: assert property (par_req.wr && par_req.addr == sls_pkg::OFS_CH1_USAGE
      && par_req.wdata > 32'(sls_pkg::CH1_USAGE_MAX) |=> par_rsp.err && par_rsp.ack)
    else $error("bad channel 1 usage accepted");
  AST_PT_FLOOR: assert property (op_mode == sls_pkg::SLS_MODE_PTORQUE && vlim_di
      |=> velocity_limit_active && velocity_limit >= sls_pkg::VEL_FLOOR_RPM)
    else $error("profile torque limit below floor");
  AST_DI_LIMIT_APPLIES: assert property (vlim_di && op_mode == sls_pkg::SLS_MODE_PVEL
      |=> velocity_limit <= $past(di_vlim_q))
    else $error("velocity above digital limit");
  AST_NO_INVERT_OTHER: assert property (op_mode == sls_pkg::SLS_MODE_OTHER |=> analog_ch1_eval == $past(analog_input_one))
    else $error("inversion outside profile modes");
  AST_CH1_INVERTS: assert property (inv1 && analog_input_one != 16'sh8000
      |=> analog_ch1_eval == -$past(analog_input_one))
    else $error("channel 1 not inverted");

  // Refused writes must leave the stored value untouched
  AST_CH2_RANGE: assert property (par_req.wr && par_req.addr == sls_pkg::OFS_CH2_USAGE
      && par_req.wdata > 32'(sls_pkg::CH2_USAGE_MAX) |=> par_rsp.err && $stable(ch2_use_q))
    else $error("bad channel 2 usage accepted");
  AST_VFS_ZERO_REFUSED: assert property (par_req.wr && par_req.addr == sls_pkg::OFS_CH1_VFS
      && par_req.wdata == 32'h00000000 |=> par_rsp.err && $stable(ch1_vfs_q))
    else $error("zero full scale accepted");
  AST_DI_RANGE: assert property (par_req.wr && par_req.addr == sls_pkg::OFS_DI_VLIM
      && par_req.wdata > sls_pkg::VLIM_MAX |=> par_rsp.err && $stable(di_vlim_q))
    else $error("digital limit above range accepted");

  // Cap only provable when the global maximum is at or above the floor, since the floor wins
  AST_ANALOG_CAP: assert property (ch1_use_act_q == sls_pkg::USE_VEL_LIMIT
      && global_max_velocity >= sls_pkg::VEL_FLOOR_RPM |=> velocity_limit <= $past(global_max_velocity))
    else $error("analog limit above global maximum");
  AST_NO_SOURCE: assert property (ch1_use_act_q != sls_pkg::USE_VEL_LIMIT
      && ch2_use_act_q != sls_pkg::USE_VEL_LIMIT && !vlim_di
      |=> !velocity_limit_active && velocity_limit == sls_pkg::VLIM_MAX)
    else $error("velocity limit with no source");

  // New stop current must bound the limit one cycle after it is stored
  sequence s_qs_store;
    par_req.wr && par_req.addr == sls_pkg::OFS_QS_CURRENT && par_req.wdata[31:16] == 16'h0000;
  endsequence

  AST_QS_TAKES_HOLD: assert property (s_qs_store ##1 quick_stop_active
      |=> current_limit <= $past(par_req.wdata[15:0], 2))
    else $error("new stop current not applied at once");

endmodule : sls_limit_select

/* File: sls_fb_master.sv */
// Fieldbus master model that issues parameter requests to the limit selection block
`timescale 1ns/1ps
module sls_fb_master (
  input wire logic clk_sys,
  input wire sls_pkg::sls_par_rsp_t par_rsp,
  output sls_pkg::sls_par_req_t par_req
);
  // Bus idle from time zero
  initial
  begin
    par_req = '0;
  end

  // One request: launched after an edge, dropped after the taking edge, answer read once it has landed
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata, input int gap,
                        output logic ack, output logic err, output logic [31:0] rdata);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    par_req <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge clk_sys);
    // A held strobe would repeat the write; released fields show the inverse
    par_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    #1;
    ack = par_rsp.ack;
    err = par_rsp.err;
    rdata = par_rsp.rdata;
  endtask : access
endmodule : sls_fb_master

/* File: sls_limit_select_bench.sv */
// Self-checking bench for the servo limit selection block
`timescale 1ns/1ps
module sls_limit_select_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  sls_pkg::sls_par_req_t par_req;
  sls_pkg::sls_par_rsp_t par_rsp;
  logic stage_enabled = 1'b0;
  logic quick_stop_active = 1'b0;
  sls_pkg::sls_mode_t op_mode = sls_pkg::SLS_MODE_OTHER;
  logic [15:0] motor_max_current = 16'h0000;
  logic [15:0] power_stage_max_current = 16'h0000;
  logic [15:0] thermal_overload_monitor = 16'h0000;
  logic [31:0] global_max_velocity = 32'h00000000;
  logic signed [15:0] analog_input_one = 16'h0000;
  logic signed [15:0] analog_input_two = 16'h0000;
  logic invert_ch1_pin = 1'b0;
  logic invert_ch2_pin = 1'b0;
  logic vel_limit_pin = 1'b0;
  logic [15:0] current_limit;
  logic [31:0] velocity_limit;
  logic velocity_limit_active;
  logic signed [15:0] analog_ch1_eval;
  logic signed [15:0] analog_ch2_eval;
  logic [15:0] analog_ch1_usage_act;
  logic [15:0] analog_ch2_usage_act;
  int n_errors = 0;
  int n_tests = 0;
  // Model of stored and working parameters
  int m_use1 = 1;
  int m_use2 = 0;
  int m_act1 = 1;
  int m_act2 = 0;
  longint m_fs1 = 3000;
  longint m_fs2 = 3000;
  longint m_dil = 10;
  longint m_qs = 65535;
  logic [31:0] rd;
  logic [15:0] rst_ofs [6] = '{sls_pkg::OFS_DI_VLIM, sls_pkg::OFS_CH1_USAGE, sls_pkg::OFS_CH1_VFS,
                               sls_pkg::OFS_CH2_USAGE, sls_pkg::OFS_CH2_VFS, sls_pkg::OFS_QS_CURRENT};
  logic [31:0] rst_val [6] = '{32'h0000000a, 32'h00000001, 32'h00000bb8, 32'h00000000, 32'h00000bb8, 32'h0000ffff};

  sls_fb_master u_sls_fb_master (.clk_sys(clk_sys), .par_rsp(par_rsp), .par_req(par_req));

  sls_limit_select u_sls_limit_select (
    .clk_sys(clk_sys), .rst_n(rst_n), .par_req(par_req), .par_rsp(par_rsp), .stage_enabled(stage_enabled),
    .quick_stop_active(quick_stop_active), .op_mode(op_mode), .motor_max_current(motor_max_current),
    .power_stage_max_current(power_stage_max_current), .thermal_overload_monitor(thermal_overload_monitor),
    .global_max_velocity(global_max_velocity), .analog_input_one(analog_input_one),
    .analog_input_two(analog_input_two), .invert_ch1_pin(invert_ch1_pin), .invert_ch2_pin(invert_ch2_pin),
    .vel_limit_pin(vel_limit_pin), .current_limit(current_limit), .velocity_limit(velocity_limit),
    .velocity_limit_active(velocity_limit_active), .analog_ch1_eval(analog_ch1_eval),
    .analog_ch2_eval(analog_ch2_eval), .analog_ch1_usage_act(analog_ch1_usage_act),
    .analog_ch2_usage_act(analog_ch2_usage_act));

  // Free-running system clock
  always #5 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic final_report();
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Value compare, four-state exact
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // Flag compare
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // Parameter access with answer check; gap varies the request spacing
  task automatic reg_acc(input logic wr, input logic [15:0] addr, input logic [31:0] wdata, input logic exp_err);
    logic ack;
    logic err;
    u_sls_fb_master.access(wr, addr, wdata, $urandom_range(2, 0), ack, err, rd);
    chk1(ack, 1'b1);
    chk1(err, exp_err);
  endtask : reg_acc

  // Evaluated analog code; inversion counts only in the two profile modes
  function automatic logic signed [15:0] ev(input logic signed [15:0] a, input logic p);
    if (p && op_mode != sls_pkg::SLS_MODE_OTHER)
      return (a == -16'sd32768) ? 16'sd32767 : -a;
    return a;
  endfunction : ev

  // Analog limit from the raw code magnitude, so inversion never moves it; floor wins over global cap
  function automatic longint ana_vel(input logic signed [15:0] e, input longint fs);
    longint v;
    v = (((e < 0) ? -longint'(e) : longint'(e)) * fs) >> 15;
    if (v > longint'(global_max_velocity))
      v = global_max_velocity;
    if (v < 100)
      v = 100;
    return v;
  endfunction : ana_vel

  // Compare every limit output against the model
  task automatic check_limits();
    longint v;
    longint c;
    longint di;
    v = (m_act1 == 3) ? ana_vel(analog_input_one, m_fs1) : 64'h7fffffff;
    if (m_act2 == 3 && ana_vel(analog_input_two, m_fs2) < v)
      v = ana_vel(analog_input_two, m_fs2);
    di = (op_mode == sls_pkg::SLS_MODE_PTORQUE && m_dil < 100) ? 100 : m_dil;
    if (vel_limit_pin && di < v)
      v = di;
    c = motor_max_current;
    if (power_stage_max_current < c)
      c = power_stage_max_current;
    if (thermal_overload_monitor < c)
      c = thermal_overload_monitor;
    if (quick_stop_active && m_qs < c)
      c = m_qs;
    chk32(32'(analog_ch1_eval), 32'(ev(analog_input_one, invert_ch1_pin)));
    chk32(32'(analog_ch2_eval), 32'(ev(analog_input_two, invert_ch2_pin)));
    chk32(velocity_limit, 32'(v));
    chk1(velocity_limit_active, m_act1 == 3 || m_act2 == 3 || vel_limit_pin);
    chk32(32'(current_limit), 32'(c));
    chk32(32'(analog_ch1_usage_act), 32'(m_act1));
    chk32(32'(analog_ch2_usage_act), 32'(m_act2));
  endtask : check_limits

  // Hang guard, well beyond the expected run of about six hundred cycles
  initial
  begin
    #1000000;
    n_errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    void'($urandom(99));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_acc(1'b0, 16'h0100, 32'h0, 1'b1);
    reg_acc(1'b1, 16'h0100, 32'h0, 1'b1);
    reg_acc(1'b1, sls_pkg::OFS_CH1_VFS, 32'h0, 1'b1);
    reg_acc(1'b1, sls_pkg::OFS_CH2_VFS, 32'h80000000, 1'b1);
    reg_acc(1'b1, sls_pkg::OFS_DI_VLIM, 32'h80000000, 1'b1);
    reg_acc(1'b1, sls_pkg::OFS_QS_CURRENT, 32'h00010000, 1'b1);
    reg_acc(1'b1, sls_pkg::OFS_CH2_USAGE, 32'h00000006, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      reg_acc(1'b0, rst_ofs[i], 32'h0, 1'b0);
      chk32(rd, rst_val[i]);
    end
    reg_acc(1'b1, sls_pkg::OFS_DI_VLIM, 32'h7fffffff, 1'b0);
    reg_acc(1'b0, sls_pkg::OFS_DI_VLIM, 32'h0, 1'b0);
    chk32(rd, 32'h7fffffff);
    // Every usage code on both channels, then random traffic with that setting working
    for (int u = 0; u <= 5; u++)
    begin
      @(posedge clk_sys);
      stage_enabled <= 1'b0;
      reg_acc(1'b1, sls_pkg::OFS_CH1_USAGE, 32'(u), u > 4);
      m_use1 = (u > 4) ? m_use1 : u;
      reg_acc(1'b1, sls_pkg::OFS_CH2_USAGE, 32'(u), 1'b0);
      m_use2 = u;
      m_fs1 = $urandom_range(20000, 1);
      m_fs2 = $urandom_range(20000, 1);
      reg_acc(1'b1, sls_pkg::OFS_CH1_VFS, 32'(m_fs1), 1'b0);
      reg_acc(1'b1, sls_pkg::OFS_CH2_VFS, 32'(m_fs2), 1'b0);
      chk32(32'(analog_ch1_usage_act), 32'(m_act1));
      chk32(32'(analog_ch2_usage_act), 32'(m_act2));
      @(posedge clk_sys);
      stage_enabled <= 1'b1;
      m_act1 = m_use1;
      m_act2 = m_use2;
      reg_acc(1'b1, sls_pkg::OFS_CH2_USAGE, 32'h3, 1'b1);
      reg_acc(1'b1, sls_pkg::OFS_CH1_VFS, 32'h5, 1'b1);
      m_qs = $urandom_range(65535, 0);
      reg_acc(1'b1, sls_pkg::OFS_QS_CURRENT, 32'(m_qs), 1'b0);
      reg_acc(1'b0, sls_pkg::OFS_QS_CURRENT, 32'h0, 1'b0);
      chk32(rd, 32'(m_qs));
      m_dil = $urandom_range(300, 0);
      reg_acc(1'b1, sls_pkg::OFS_DI_VLIM, 32'(m_dil), 1'b0);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge clk_sys);
        op_mode <= sls_pkg::sls_mode_t'($urandom_range(2, 0));
        quick_stop_active <= 1'($urandom_range(1, 0));
        motor_max_current <= 16'($urandom);
        power_stage_max_current <= 16'($urandom);
        thermal_overload_monitor <= 16'($urandom);
        global_max_velocity <= $urandom_range(5000, 50);
        // Most negative code once per channel, to reach the saturating inversion
        analog_input_one <= (k == 0) ? 16'sh8000 : 16'($urandom_range(65534, 0) - 32767);
        analog_input_two <= (k == 1) ? 16'sh8000 : 16'($urandom_range(65534, 0) - 32767);
        invert_ch1_pin <= 1'($urandom_range(1, 0));
        invert_ch2_pin <= 1'($urandom_range(1, 0));
        vel_limit_pin <= 1'($urandom_range(1, 0));
        repeat (6) @(posedge clk_sys);
        #1;
        check_limits();
      end
    end
    final_report();
  end
endmodule : sls_limit_select_bench
